// [verilog/ulp_cfg.svh]
// Constants for the low-power divisor latch of the infrared-capable UART.
// Assumes inclusion by bare name from the package and the design modules.
//
// Contract
// - The divisor is 16 bits wide, with the low byte register giving bits 7:0 and the high byte register giving bits 15:8, both read and write.
// - Either divisor byte register can be reached only while the divisor latch access bit (bit 7 of the line control register) is set.
// - The low-power baud rate is the serial clock divided by sixteen times the 16-bit divisor.
// - The low-power baud clock times the minimum-pulse-width check of pulses on the infrared receive line.
// - With both divisor bytes at zero the low-power baud clock stops and the receiver detects no pulses at all.
`ifndef ULP_CFG_SVH
`define ULP_CFG_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define ULP_ADDR_W 32
`define ULP_DATA_W 16
`define ULP_BYTE_W 8
`define ULP_DIV_W 16
`define ULP_OVS_W 4
`define ULP_PW_W 4

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define ULP_ADDR_DIV_LOW 32'h5000_1020
`define ULP_ADDR_DIV_HIGH 32'h5000_1024

// ----------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------
`define ULP_DIV_BYTE_RESET 8'h00
`define ULP_DIV_ZERO 16'h0000
`define ULP_DIV_ONE 16'h0001
`define ULP_RD_IDLE 16'h0000
`define ULP_RSVD_HIGH 8'h00
`define ULP_OVS_ZERO 4'h0
`define ULP_OVS_ONE 4'h1
`define ULP_OVS_LAST 4'hF
`define ULP_PW_ZERO 4'h0
`define ULP_PW_ONE 4'h1
`define ULP_MIN_PULSE_TICKS 4'h2

`endif

// [verilog/ulp_pkg.sv]
// Types shared by the low-power divisor latch and its baud divider.
// Assumes ulp_cfg.svh is on the include path.
`include "ulp_cfg.svh"

package ulp_pkg;

	// ------------------------------------------------------------------
	// Register port request
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [`ULP_ADDR_W-1:0] addr;
		logic [`ULP_DATA_W-1:0] wrData;
		logic wr;
		logic rd;
	} ulp_reg_req_t;

	// ------------------------------------------------------------------
	// Divider tick outputs
	// ------------------------------------------------------------------
	typedef struct packed {
		logic tick16;
		logic baudTick;
	} ulp_tick_t;

	// ------------------------------------------------------------------
	// Pulse detector states
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PD_IDLE,
		PD_MEASURE,
		PD_HOLD
	} ulp_pd_state_t;

endpackage

// [verilog/ulp_baud_div.sv]
// Low-power baud divider: a 16x oversample tick every divisor cycles
// and a baud tick every sixteen oversample ticks.
// Assumes one clock and a divisor that is stable except around restart.
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module ulp_baud_div (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [`ULP_DIV_W-1:0] divisor,
	input wire logic restart,
	output ulp_pkg::ulp_tick_t ticks
);

	logic [`ULP_DIV_W-1:0] cnt_r;
	logic [`ULP_DIV_W-1:0] cnt_nxt;
	logic [`ULP_OVS_W-1:0] ovs_r;
	logic [`ULP_OVS_W-1:0] ovs_nxt;
	ulp_pkg::ulp_tick_t ticks_r;
	ulp_pkg::ulp_tick_t ticks_nxt;
	logic [`ULP_DIV_W-1:0] reload;

	// Reload value is divisor minus one so a tick comes every divisor cycles
	assign reload = `ULP_DIV_W'(divisor - `ULP_DIV_ONE);

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		cnt_nxt = cnt_r;
		ovs_nxt = ovs_r;
		ticks_nxt.tick16 = 1'b0;
		ticks_nxt.baudTick = 1'b0;
		if (divisor == `ULP_DIV_ZERO) begin
			cnt_nxt = `ULP_DIV_ZERO;
			ovs_nxt = `ULP_OVS_ZERO;
		end else if (restart) begin
			cnt_nxt = reload;
			ovs_nxt = `ULP_OVS_ZERO;
		end else if (cnt_r == `ULP_DIV_ZERO) begin
			cnt_nxt = reload;
			ticks_nxt.tick16 = 1'b1;
			ovs_nxt = `ULP_OVS_W'(ovs_r + `ULP_OVS_ONE);
			ticks_nxt.baudTick = (ovs_r == `ULP_OVS_LAST);
		end else begin
			cnt_nxt = `ULP_DIV_W'(cnt_r - `ULP_DIV_ONE);
		end
	end

	// Registers only
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_r <= `ULP_DIV_ZERO;
			ovs_r <= `ULP_OVS_ZERO;
			ticks_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			ovs_r <= ovs_nxt;
			ticks_r <= ticks_nxt;
		end
	end

	assign ticks = ticks_r;

endmodule

// [verilog/ulp_divisor_latch.sv]
// Low-power divisor latch with its baud divider and the infrared
// minimum-pulse-width detector that the low-power clock times.
// Assumes the line control register lives outside and drives the access
// bit on the same clock; the infrared receive line is an async pin.
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module ulp_divisor_latch (
	input wire logic core_clk,
	input wire logic rst,
	input ulp_pkg::ulp_reg_req_t regReq,
	output logic [`ULP_DATA_W-1:0] regRdData,
	input wire logic divisorLatchAccess,
	input wire logic pulseDetectEn,
	input wire logic sirIn,
	output logic [`ULP_DIV_W-1:0] lpDivisor,
	output logic lpClkActive,
	output ulp_pkg::ulp_tick_t lpTicks,
	output logic sirPulse,
	output logic sirRxLevel
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------

	// Address match, used by both the write and the read decode
	function automatic logic addrIs(input logic [`ULP_ADDR_W-1:0] a,
			input logic [`ULP_ADDR_W-1:0] target);
		addrIs = (a == target);
	endfunction

	// Any nonzero divisor means the low-power clock runs
	function automatic logic divNonzero(input logic [`ULP_BYTE_W-1:0] lo,
			input logic [`ULP_BYTE_W-1:0] hi);
		divNonzero = ({hi, lo} != `ULP_DIV_ZERO);
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [`ULP_BYTE_W-1:0] divLow_r;
	logic [`ULP_BYTE_W-1:0] divLow_nxt;
	logic [`ULP_BYTE_W-1:0] divHigh_r;
	logic [`ULP_BYTE_W-1:0] divHigh_nxt;
	logic [`ULP_DATA_W-1:0] rdData_r;
	logic [`ULP_DATA_W-1:0] rdData_nxt;
	logic restart_r;
	logic restart_nxt;
	logic clkActive_r;
	logic clkActive_nxt;
	logic hitLow;
	logic hitHigh;

	logic sirSync1_r;
	logic sirSync2_r;
	logic sirSync3_r;
	logic sirLevel_r;
	logic sirLevel_nxt;

	ulp_pkg::ulp_pd_state_t pdState_r;
	ulp_pkg::ulp_pd_state_t pdState_nxt;
	logic [`ULP_PW_W-1:0] pwCnt_r;
	logic [`ULP_PW_W-1:0] pwCnt_nxt;
	logic pulse_r;
	logic pulse_nxt;
	logic rxLevel_r;
	logic rxLevel_nxt;
	logic detectOn;
	ulp_pkg::ulp_tick_t ticks;

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------

	// Address hits, qualified by the access bit
	// access bit gates
	assign hitLow = divisorLatchAccess && addrIs(regReq.addr, `ULP_ADDR_DIV_LOW);
	assign hitHigh = divisorLatchAccess && addrIs(regReq.addr, `ULP_ADDR_DIV_HIGH);

	// Write and read decode; read data stand for one cycle only
	always_comb begin
		divLow_nxt = divLow_r;
		divHigh_nxt = divHigh_r;
		restart_nxt = 1'b0;
		rdData_nxt = `ULP_RD_IDLE;
		if (regReq.wr && hitLow) begin
			divLow_nxt = regReq.wrData[`ULP_BYTE_W-1:0];
		end
		if (regReq.wr && hitHigh) begin
			divHigh_nxt = regReq.wrData[`ULP_BYTE_W-1:0];
		end
		if (regReq.wr && (hitLow || hitHigh)) begin
			restart_nxt = 1'b1;
		end
		if (regReq.rd && hitLow) begin
			rdData_nxt = {`ULP_RSVD_HIGH, divLow_r};
		end else if (regReq.rd && hitHigh) begin
			rdData_nxt = {`ULP_RSVD_HIGH, divHigh_r};
		end
	end

	// Divisor bytes, read data and restart strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			divLow_r <= `ULP_DIV_BYTE_RESET;
			divHigh_r <= `ULP_DIV_BYTE_RESET;
			rdData_r <= `ULP_RD_IDLE;
			restart_r <= 1'b0;
		end else begin
			divLow_r <= divLow_nxt;
			divHigh_r <= divHigh_nxt;
			rdData_r <= rdData_nxt;
			restart_r <= restart_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Low-power clock enable
	// ------------------------------------------------------------------

	// Registered so the status output comes from a flop
	always_comb begin
		clkActive_nxt = divNonzero(divLow_r, divHigh_r);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			clkActive_r <= 1'b0;
		end else begin
			clkActive_r <= clkActive_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Baud divider
	// ------------------------------------------------------------------

	// Restart arrives one cycle after the write, with the new byte in place
	// oversample divider
	ulp_baud_div uDiv (
		.core_clk(core_clk),
		.rst(rst),
		.divisor({divHigh_r, divLow_r}),
		.restart(restart_r),
		.ticks(ticks)
	);

	// ------------------------------------------------------------------
	// Infrared input synchroniser
	// ------------------------------------------------------------------

	// Three-stage chain; the first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sirSync1_r <= 1'b0;
			sirSync2_r <= 1'b0;
			sirSync3_r <= 1'b0;
		end else begin
			sirSync1_r <= sirIn;
			sirSync2_r <= sirSync1_r;
			sirSync3_r <= sirSync2_r;
		end
	end

	// Level moves only once stages two and three agree
	always_comb begin
		sirLevel_nxt = sirLevel_r;
		if (sirSync2_r == sirSync3_r) begin
			sirLevel_nxt = sirSync3_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sirLevel_r <= 1'b0;
		end else begin
			sirLevel_r <= sirLevel_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Minimum pulse width detector
	// ------------------------------------------------------------------

	// Detection needs the receiver enable and a running low-power clock
	// no detection when stopped
	assign detectOn = pulseDetectEn && clkActive_r;

	// A pulse must stay high across the minimum count of oversample ticks.
	// Shorter glitches are dropped; the tick grid trades up to one tick of
	// width uncertainty for needing no fast counter on the pin.
	always_comb begin
		pdState_nxt = pdState_r;
		pwCnt_nxt = pwCnt_r;
		pulse_nxt = 1'b0;
		rxLevel_nxt = rxLevel_r;
		if (!detectOn) begin
			pdState_nxt = ulp_pkg::PD_IDLE;
			pwCnt_nxt = `ULP_PW_ZERO;
			rxLevel_nxt = 1'b0;
		end else begin
			case (pdState_r)
				ulp_pkg::PD_IDLE: begin
					rxLevel_nxt = 1'b0;
					pwCnt_nxt = `ULP_PW_ZERO;
					if (sirLevel_r) begin
						pdState_nxt = ulp_pkg::PD_MEASURE;
					end
				end
				ulp_pkg::PD_MEASURE: begin
					if (!sirLevel_r) begin
						pdState_nxt = ulp_pkg::PD_IDLE;
						pwCnt_nxt = `ULP_PW_ZERO;
					end else if (ticks.tick16) begin
						pwCnt_nxt = `ULP_PW_W'(pwCnt_r + `ULP_PW_ONE);
						if (`ULP_PW_W'(pwCnt_r + `ULP_PW_ONE) == `ULP_MIN_PULSE_TICKS) begin
							pdState_nxt = ulp_pkg::PD_HOLD;
							pulse_nxt = 1'b1;
							rxLevel_nxt = 1'b1;
						end
					end
				end
				ulp_pkg::PD_HOLD: begin
					// One accepted pulse per high period
					if (!sirLevel_r) begin
						pdState_nxt = ulp_pkg::PD_IDLE;
						pwCnt_nxt = `ULP_PW_ZERO;
						rxLevel_nxt = 1'b0;
					end
				end
				default: begin
					pdState_nxt = ulp_pkg::PD_IDLE;
					pwCnt_nxt = `ULP_PW_ZERO;
					rxLevel_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pdState_r <= ulp_pkg::PD_IDLE;
			pwCnt_r <= `ULP_PW_ZERO;
			pulse_r <= 1'b0;
			rxLevel_r <= 1'b0;
		end else begin
			pdState_r <= pdState_nxt;
			pwCnt_r <= pwCnt_nxt;
			pulse_r <= pulse_nxt;
			rxLevel_r <= rxLevel_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all from flops
	// ------------------------------------------------------------------
	assign regRdData = rdData_r;
	assign lpDivisor = {divHigh_r, divLow_r};
	assign lpClkActive = clkActive_r;
	assign lpTicks = ticks;
	assign sirPulse = pulse_r;
	assign sirRxLevel = rxLevel_r;

endmodule

// [tb/ulp_latch_monitor.sv]
// Port checker for the low-power divisor latch.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module ulp_latch_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input ulp_pkg::ulp_reg_req_t regReq,
	input wire logic [`ULP_DATA_W-1:0] regRdData,
	input wire logic divisorLatchAccess,
	input wire logic pulseDetectEn,
	input wire logic sirIn,
	input wire logic [`ULP_DIV_W-1:0] lpDivisor,
	input wire logic lpClkActive,
	input ulp_pkg::ulp_tick_t lpTicks,
	input wire logic sirPulse,
	input wire logic sirRxLevel
);
	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic lo;
	logic hi;
	logic gate;
	// Address decode, gated by the latch access bit
	assign lo = regReq.addr == `ULP_ADDR_DIV_LOW;
	assign hi = regReq.addr == `ULP_ADDR_DIV_HIGH;
	assign gate = divisorLatchAccess && (lo || hi);

	AST_RD_LO: assert property (regReq.rd && gate && lo
		|=> regRdData == {8'h00, $past(lpDivisor[7:0])}) else $error("low byte read wrong");
	AST_RD_HI: assert property (regReq.rd && gate && hi
		|=> regRdData == {8'h00, $past(lpDivisor[15:8])}) else $error("high byte read wrong");
	AST_RD_DENY: assert property (regReq.rd && !gate |=> regRdData == 16'h0000)
		else $error("refused read returned data");
	AST_WR_DENY: assert property (regReq.wr && !gate |=> $stable(lpDivisor))
		else $error("refused write changed divisor");
	AST_WR_LO: assert property (regReq.wr && gate && lo
		|=> lpDivisor == {$past(lpDivisor[15:8]), $past(regReq.wrData[7:0])})
		else $error("low byte write wrong");
	AST_WR_HI: assert property (regReq.wr && gate && hi
		|=> lpDivisor == {$past(regReq.wrData[7:0]), $past(lpDivisor[7:0])})
		else $error("high byte write wrong");
	AST_ACTIVE: assert property (lpClkActive == ($past(lpDivisor) != 16'h0000))
		else $error("clock active flag wrong");
	// Three quiet cycles let the last pre-zero tick drain out
	AST_OFF: assert property (lpDivisor == 16'h0000 && $past(lpDivisor) == 16'h0000
		&& $past(lpDivisor, 2) == 16'h0000 |-> !lpTicks.tick16 && !sirPulse && !sirRxLevel)
		else $error("activity with zero divisor");
	// A write one cycle before the tick restarts the count under it, so leave that case out
	AST_PERIOD: assert property ((lpTicks.tick16 && lpDivisor == 16'h0005 && !regReq.wr
		&& !$past(regReq.wr)) ##1 !regReq.wr [*4] |=> lpTicks.tick16 && !$past(lpTicks.tick16))
		else $error("oversample period wrong");
	AST_BAUD: assert property (lpTicks.baudTick |-> lpTicks.tick16)
		else $error("baud tick off oversample tick");
	AST_PULSE: assert property (sirPulse |-> sirRxLevel ##1 !sirPulse)
		else $error("pulse not a single cycle");
	AST_NODET: assert property (!pulseDetectEn |=> !sirPulse && !sirRxLevel)
		else $error("detection while disabled");

	// Main scenarios reached
	cover property (lpTicks.baudTick);
	cover property (sirPulse);
	cover property (regReq.wr && gate && hi);
endmodule

bind ulp_divisor_latch ulp_latch_monitor mon (.core_clk(core_clk), .rst(rst),
	.regReq(regReq), .regRdData(regRdData), .divisorLatchAccess(divisorLatchAccess),
	.pulseDetectEn(pulseDetectEn), .sirIn(sirIn), .lpDivisor(lpDivisor),
	.lpClkActive(lpClkActive), .lpTicks(lpTicks), .sirPulse(sirPulse),
	.sirRxLevel(sirRxLevel));

// [tb/ulp_sir_xcvr.sv]
// Infrared transceiver model driving the receive line.
// Assumes the bench calls pulse from a clocked context.
`timescale 1ns/1ns

module ulp_sir_xcvr (
	input wire logic core_clk,
	output logic sirIn
);
	// Dark line reads low; light gives a high pulse
	initial sirIn = 1'b0;
	task automatic pulse(input int w);
		@(posedge core_clk);
		sirIn <= 1'b1;
		repeat (w) @(posedge core_clk);
		sirIn <= 1'b0;
	endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the low-power divisor latch.
// Assumes the checker is bound to the latch by its own file.
`timescale 1ns/1ns
`include "ulp_cfg.svh"

module testbench;
	// ------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	ulp_pkg::ulp_reg_req_t req = '0;
	logic acc = 1'b0;
	logic pde = 1'b0;
	logic sirIn;
	logic [15:0] rdData;
	logic [15:0] div;
	logic lpAct;
	logic sirPulse;
	logic sirLvl;
	ulp_pkg::ulp_tick_t ticks;
	logic rdD = 1'b0;
	logic [15:0] expQ[$];
	logic [15:0] d;
	logic [15:0] e;
	int error_cnt = 0;
	int comparisons = 0;
	int tickN = 0;
	int baudN = 0;
	int pulseN = 0;
	int n0;
	int p0;
	int k;

	always #2 core_clk = ~core_clk;

	ulp_divisor_latch uut (.core_clk(core_clk), .rst(rst), .regReq(req), .regRdData(rdData),
		.divisorLatchAccess(acc), .pulseDetectEn(pde), .sirIn(sirIn), .lpDivisor(div),
		.lpClkActive(lpAct), .lpTicks(ticks), .sirPulse(sirPulse), .sirRxLevel(sirLvl));
	ulp_sir_xcvr xcvr (.core_clk(core_clk), .sirIn(sirIn));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic results();
		$display("counts: %0d compares, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Strobes wait an edge first so no task lowers and raises in one step
	task automatic wr(input logic [31:0] a, input logic [15:0] v);
		@(posedge core_clk);
		req.addr <= a;
		req.wrData <= v;
		req.wr <= 1'b1;
		@(posedge core_clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [15:0] v);
		@(posedge core_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		expQ.push_back(v);
		@(posedge core_clk);
		req.rd <= 1'b0;
	endtask

	// Watcher: read data one cycle after the strobe, event counts
	always @(posedge core_clk) begin
		rdD <= req.rd;
		if (ticks.tick16 === 1'b1) tickN <= tickN + 1;
		if (ticks.baudTick === 1'b1) baudN <= baudN + 1;
		if (sirPulse === 1'b1) pulseN <= pulseN + 1;
		if (rdD === 1'b1 && expQ.size() > 0) chk(rdData, expQ.pop_front(), "read");
	end

	initial begin
		void'($urandom(84));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		acc <= 1'b1;
		rd(`ULP_ADDR_DIV_LOW, 16'h0000);
		rd(`ULP_ADDR_DIV_HIGH, 16'h0000);
		$display("test reset values done");
		// Gate low: write dropped, read empty; unmapped place too
		acc <= 1'b0;
		wr(`ULP_ADDR_DIV_LOW, 16'h00A5);
		rd(`ULP_ADDR_DIV_LOW, 16'h0000);
		acc <= 1'b1;
		rd(`ULP_ADDR_DIV_LOW, 16'h0000);
		wr(32'h5000_1028, 16'h0011);
		rd(32'h5000_1028, 16'h0000);
		$display("test access gate done");
		// Random bytes; upper write bits must be dropped
		for (int i = 0; i < 4; i++) begin
			d = 16'($urandom);
			e = 16'($urandom);
			wr(`ULP_ADDR_DIV_LOW, d);
			wr(`ULP_ADDR_DIV_HIGH, e);
			rd(`ULP_ADDR_DIV_LOW, {8'h00, d[7:0]});
			rd(`ULP_ADDR_DIV_HIGH, {8'h00, e[7:0]});
			chk(div, {e[7:0], d[7:0]}, "divisor");
		end
		$display("test byte pairing done");
		// Divisor 5: 32 oversample and 2 baud ticks in 160 cycles
		wr(`ULP_ADDR_DIV_HIGH, 16'h0000);
		wr(`ULP_ADDR_DIV_LOW, 16'h0005);
		repeat (10) @(posedge core_clk);
		n0 = tickN;
		p0 = baudN;
		repeat (160) @(posedge core_clk);
		chk(16'(tickN - n0), 16'h0020, "tick count");
		chk(16'(baudN - p0), 16'h0002, "baud count");
		// Rewrites every two cycles keep the count from ever expiring
		wr(`ULP_ADDR_DIV_LOW, 16'h0005);
		wr(`ULP_ADDR_DIV_LOW, 16'h0005);
		n0 = tickN;
		repeat (8) wr(`ULP_ADDR_DIV_LOW, 16'h0005);
		chk(16'(tickN - n0), 16'h0000, "restart");
		$display("test divider done");
		// Zero divisor: clock off, a long pulse goes unseen
		wr(`ULP_ADDR_DIV_LOW, 16'h0000);
		pde <= 1'b1;
		repeat (8) @(posedge core_clk);
		n0 = tickN;
		p0 = pulseN;
		xcvr.pulse(400);
		repeat (20) @(posedge core_clk);
		chk(16'(tickN - n0), 16'h0000, "ticks off");
		chk(16'(pulseN - p0), 16'h0000, "pulse off");
		chk({15'h0000, lpAct}, 16'h0000, "active off");
		$display("test zero divisor done");
		// Divisor 0x88 gives the nearest rate to 115.2K at this clock
		wr(`ULP_ADDR_DIV_LOW, 16'h0088);
		repeat (8) @(posedge core_clk);
		chk({15'h0000, lpAct}, 16'h0001, "active on");
		p0 = pulseN;
		xcvr.pulse(20 + $urandom % 100);
		repeat (20) @(posedge core_clk);
		chk(16'(pulseN - p0), 16'h0000, "short pulse");
		xcvr.pulse(300 + $urandom % 100);
		chk(16'(pulseN - p0), 16'h0001, "long pulse");
		chk({15'h0000, sirLvl}, 16'h0001, "level held");
		for (k = 0; k < 40 && sirLvl !== 1'b0; k++) @(posedge core_clk);
		// A stuck level counts as a mismatch; the run still ends in the one report
		if (k == 40) begin
			error_cnt++;
			$display("MISMATCH t=%0t level never fell", $time);
		end
		// Enable low: the same pulse is ignored
		pde <= 1'b0;
		xcvr.pulse(400);
		chk(16'(pulseN - p0), 16'h0001, "disabled");
		$display("test pulse detect done");
		results();
	end
endmodule
